// *** hdl/sps_pkg.sv ***
// constants and types shared by the protection sequencer files
package sps_pkg;
  // ***********************************************************
  // clock and timing
  // ***********************************************************
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned SS_TIME_US     = 3_500;
  localparam int unsigned SS_CYC         = SS_TIME_US * CYC_PER_US;
  localparam int unsigned BO_TIME_MS     = 32;
  localparam int unsigned BO_CYC         = BO_TIME_MS * 1_000 * CYC_PER_US;
  localparam int unsigned OPP_TIME_MS    = 60;
  localparam int unsigned OPP_CYC        = OPP_TIME_MS * 1_000 * CYC_PER_US;
  localparam int unsigned SW_FREQ_HZ     = 65_000;
  localparam int unsigned SW_PERIOD_CYC  = CLK_HZ / SW_FREQ_HZ;
  localparam int unsigned MAX_DUTY_PCT   = 80;
  localparam int unsigned MAX_DUTY_CYC   = SW_PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int unsigned LP_FACTOR      = 2;
  localparam int unsigned PHASE_TIME_US  = 100;
  localparam int unsigned PHASE_CYC      = PHASE_TIME_US * CYC_PER_US;
  // ***********************************************************
  // levels and counts
  // ***********************************************************
  localparam int unsigned PEAK_W         = 8;
  localparam int unsigned LOW_PEAK_PCT   = 25;
  localparam int unsigned BROWNIN_DEF    = 64;
  localparam int unsigned BROWNOUT_DEF   = 56;
  localparam int unsigned MAXDUTY_RUN    = 8;
  localparam int unsigned OVP_RUN        = 4;
  localparam int unsigned OTP_RUN        = 4;
  localparam logic [1:0]  RESTART_TRIPLE = 2'h3;
  localparam logic [1:0]  RESTART_SINGLE = 2'h1;
  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_WAIT  = 6'h02,
    ST_RUN   = 6'h04,
    ST_DISCH = 6'h08,
    ST_RECH  = 6'h10,
    ST_LATCH = 6'h20
  } sps_state_t;
  typedef enum logic [2:0] {
    CS_NONE = 3'h0,
    CS_OPP  = 3'h1,
    CS_UNDERVOLTAGE_LOCKOUT = 3'h2,
    CS_BO   = 3'h3,
    CS_MAXD = 3'h4,
    CS_OVP  = 3'h5,
    CS_OTP  = 3'h6
  } sps_cause_t;
endpackage

// *** hdl/sps_stroke_if.sv ***
// stroke generator carrier between sequencer and stroke timing
`timescale 1ns/10ps
interface sps_stroke_if;
  logic enable;
  logic low_power;
  logic cs_trip;
  logic gate;
  logic cycle_end;
  logic max_hit;
  modport gen (input enable, low_power, cs_trip, output gate, cycle_end, max_hit);
  modport ctl (output enable, low_power, cs_trip, input gate, cycle_end, max_hit);
endinterface

// *** hdl/sps_timer.sv ***
// persistence counter: counts steps with condition held, clears on a miss
`timescale 1ns/10ps
module sps_timer
  import sps_pkg::*;
#(
  parameter int unsigned LIMIT = 4,
  parameter int unsigned W     = $clog2(LIMIT + 1)
)(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic clr,
  input  wire logic step,
  input  wire logic cond,
  output logic      fire
);
  logic [W-1:0] cnt;

  if (LIMIT < 1) begin : g_bad_limit
    $error("sps_timer: LIMIT must be at least 1");
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (step) begin
      if (!cond) begin
        cnt <= '0;
      end else if (cnt != W'(LIMIT)) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  assign fire = (cnt == W'(LIMIT));

  a_miss_clears: assert property (@(posedge mclk) disable iff (rst)
    (step && !cond && !clr) |=> (cnt == '0))
    else $error("count not cleared after a missed step");
  a_fire_needs_cond: assert property (@(posedge mclk) disable iff (rst)
    $rose(fire) |-> $past(cond) && $past(step))
    else $error("fire reached without a qualifying step");
endmodule // sps_timer

// *** hdl/sps_stroke.sv ***
// switching stroke timing with duty limit and low-power period stretch
`timescale 1ns/10ps
module sps_stroke
  import sps_pkg::*;
#(
  parameter int unsigned PERIOD = SW_PERIOD_CYC,
  parameter int unsigned MAXD   = MAX_DUTY_CYC,
  parameter int unsigned LPF    = LP_FACTOR
)(
  input  wire logic mclk,
  input  wire logic rst,
  sps_stroke_if.gen sw
);
  localparam int unsigned CW = $clog2(PERIOD * LPF + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] on_cnt;
  logic          period_end;

  if (MAXD < 1 || MAXD >= PERIOD || LPF < 1) begin : g_bad_cfg
    $error("sps_stroke: duty limit must lie inside the period");
  end

  // low power keeps the peak fixed and stretches the period instead
  // at-or-above, so leaving low power late in a long period cannot skip the end
  assign period_end = (cnt >= (sw.low_power ? CW'(PERIOD * LPF - 1) : CW'(PERIOD - 1)));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (!sw.enable || period_end) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw.gate <= 1'b0;
    end else if (!sw.enable) begin
      sw.gate <= 1'b0;
    end else if (cnt == CW'(MAXD)) begin
      sw.gate <= 1'b0;
    end else if (cnt == '0) begin
      sw.gate <= 1'b1;
    end else if (sw.cs_trip) begin
      sw.gate <= 1'b0;
    end
  end

  // hit flag holds through the cycle_end pulse so the counter sees it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw.max_hit <= 1'b0;
    end else if (!sw.enable || cnt == '0) begin
      sw.max_hit <= 1'b0;
    end else if (cnt == CW'(MAXD) && sw.gate) begin
      sw.max_hit <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw.cycle_end <= 1'b0;
    end else begin
      sw.cycle_end <= sw.enable && period_end;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      on_cnt <= '0;
    end else if (sw.gate) begin
      on_cnt <= on_cnt + 1'b1;
    end else begin
      on_cnt <= '0;
    end
  end

  a_duty_limit: assert property (@(posedge mclk) disable iff (rst)
    on_cnt <= CW'(MAXD))
    else $error("stroke longer than the duty limit");
endmodule // sps_stroke

// *** hdl/sps_top.sv ***
// start-up, restart and protection sequencer for a flyback controller
// Overview of operation
// - switching waits for start level, mains above brown-in and protect level
// - each start ramps the peak limit over 3.5 ms soft-start
// - any protection stops switching at once, then restart or latch
// - overpower, lockout, brownout, max duty, overvoltage, ext temp restart; die latches
// - restart waits for lockout level, then power-down until start level
// - discharge-recharge cycle runs once or three times by cause
// - latched protection enters power-down at once and stays until supply removed
// - supply below lockout while running stops switching and awaits recharge
// - internal clock alternates mains and temperature periods on protect input
// - mains period stores input current; start allowed above brown-in
// - mains below brownout for 32 ms stops switching, single restart
// - four temperature periods below protect level trigger overtemperature
// - stored mains current cancels offset and feeds line compensation
// - every stroke ends by the 80 % duty limit
// - eight consecutive max-duty strokes trigger restart protection
// - low power fixes peak at 25 % and lowers frequency
// - peak control over 400 mV for 60 ms raises overpower, triple restart
// - four consecutive cycles of supply overvoltage trigger protection, else clear
`timescale 1ns/10ps
module sps_top
  import sps_pkg::*;
#(
  parameter int unsigned SS_CYCLES     = SS_CYC,
  parameter int unsigned BO_CYCLES     = BO_CYC,
  parameter int unsigned OPP_CYCLES    = OPP_CYC,
  parameter int unsigned PW            = PEAK_W,
  parameter int unsigned BROWNIN_LVL   = BROWNIN_DEF,
  parameter int unsigned BROWNOUT_LVL  = BROWNOUT_DEF,
  parameter bit          EXT_OTP_LATCH = 1'b0
)(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          vcc_start,
  input  wire logic          undervoltage_lockout,
  input  wire logic          vcc_ovp,
  input  wire logic          protect_det,
  input  wire logic [PW-1:0] mains_current,
  input  wire logic [PW-1:0] ctrl_level,
  input  wire logic          overload,
  input  wire logic          current_sense_input,
  input  wire logic          low_power,
  input  wire logic          die_hot,
  output logic               gate,
  output logic [PW-1:0]      peak_limit,
  output logic               power_down,
  output logic               latch_clamp,
  output logic               measure_mains,
  output logic [PW-1:0]      stored_current,
  output sps_cause_t         restart_cause
);
  // ***********************************************************
  // derived constants
  // ***********************************************************
  localparam int unsigned PEAK_MAX = (2 ** PW) - 1;
  localparam logic [PW-1:0] PEAK_LOW = PW'(PEAK_MAX * LOW_PEAK_PCT / 100);
  localparam int unsigned SS_STEP = SS_CYCLES / PEAK_MAX;
  localparam int unsigned SSW = $clog2(SS_STEP + 1);
  localparam int unsigned PHW = $clog2(PHASE_CYC + 1);

  if (SS_STEP < 1 || BROWNOUT_LVL > BROWNIN_LVL || BROWNIN_LVL > PEAK_MAX) begin : g_bad_cfg
    $error("sps_top: soft-start too short or mains levels out of order");
  end

  sps_state_t     state;
  sps_state_t     next_state;
  logic [1:0]     restart_left;
  logic [PW-1:0]  ramp;
  logic [SSW-1:0] ss_pre;
  logic [PHW-1:0] phase_cnt;
  logic           phase_end;
  logic           st_run;
  logic           brownin_ok;
  logic           opp_fire;
  logic           bo_fire;
  logic           md_fire;
  logic           ovp_fire;
  logic           otp_fire;
  logic           latch_fault;
  logic           restart_fault;
  logic           fault_any;

  sps_stroke_if sw ();

  // ***********************************************************
  // measurement phases on the protect input
  // ***********************************************************
  assign phase_end = (phase_cnt == PHW'(PHASE_CYC - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_cnt <= '0;
    end else if (phase_end) begin
      phase_cnt <= '0;
    end else begin
      phase_cnt <= phase_cnt + 1'b1;
    end
  end

  // one phase at a time, so mains and temperature never overlap
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      measure_mains <= 1'b1;
    end else if (phase_end) begin
      measure_mains <= !measure_mains;
    end
  end

  // held value doubles as offset cancel and line compensation input
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stored_current <= '0;
    end else if (phase_end && measure_mains) begin
      stored_current <= mains_current;
    end
  end

  assign brownin_ok = (stored_current > PW'(BROWNIN_LVL));

  // ***********************************************************
  // fault detectors
  // ***********************************************************
  assign st_run = (state == ST_RUN);

  sps_timer #(.LIMIT(OPP_CYCLES)) u_opp (
    .mclk (mclk),
    .rst  (rst),
    .clr  (!st_run),
    .step (1'b1),
    .cond (overload),
    .fire (opp_fire)
  );

  sps_timer #(.LIMIT(BO_CYCLES)) u_bo (
    .mclk (mclk),
    .rst  (rst),
    .clr  (!st_run),
    .step (1'b1),
    .cond (stored_current < PW'(BROWNOUT_LVL)),
    .fire (bo_fire)
  );

  sps_timer #(.LIMIT(MAXDUTY_RUN)) u_md (
    .mclk (mclk),
    .rst  (rst),
    .clr  (!st_run),
    .step (sw.cycle_end),
    .cond (sw.max_hit),
    .fire (md_fire)
  );

  sps_timer #(.LIMIT(OVP_RUN)) u_ovp (
    .mclk (mclk),
    .rst  (rst),
    .clr  (!st_run),
    .step (sw.cycle_end),
    .cond (vcc_ovp),
    .fire (ovp_fire)
  );

  sps_timer #(.LIMIT(OTP_RUN)) u_otp (
    .mclk (mclk),
    .rst  (rst),
    .clr  (!st_run),
    .step (phase_end && !measure_mains),
    .cond (!protect_det),
    .fire (otp_fire)
  );

  assign latch_fault   = die_hot || (EXT_OTP_LATCH && otp_fire);
  assign restart_fault = opp_fire || undervoltage_lockout || bo_fire || md_fire ||
                         ovp_fire || (!EXT_OTP_LATCH && otp_fire);
  assign fault_any     = latch_fault || restart_fault;

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (vcc_start) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (undervoltage_lockout) next_state = ST_OFF;
        else if (brownin_ok && protect_det) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (latch_fault) next_state = ST_LATCH;
        else if (restart_fault) next_state = ST_DISCH;
      end
      ST_DISCH: begin
        if (undervoltage_lockout) next_state = ST_RECH;
      end
      ST_RECH: begin
        if (vcc_start) next_state = (restart_left > 2'h1) ? ST_DISCH : ST_WAIT;
      end
      ST_LATCH: begin
        next_state = ST_LATCH;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      restart_left <= 2'h0;
    end else if (st_run && restart_fault && !latch_fault) begin
      restart_left <= opp_fire ? RESTART_TRIPLE : RESTART_SINGLE;
    end else if (state == ST_RECH && vcc_start) begin
      restart_left <= (restart_left > 2'h1) ? restart_left - 2'h1 : 2'h0;
    end
  end

  // priority fixes one cause when several detectors fire together
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      restart_cause <= CS_NONE;
    end else if (st_run && restart_fault && !latch_fault) begin
      if (opp_fire) restart_cause <= CS_OPP;
      else if (undervoltage_lockout) restart_cause <= CS_UNDERVOLTAGE_LOCKOUT;
      else if (bo_fire) restart_cause <= CS_BO;
      else if (md_fire) restart_cause <= CS_MAXD;
      else if (ovp_fire) restart_cause <= CS_OVP;
      else restart_cause <= CS_OTP;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_down  <= 1'b1;
      latch_clamp <= 1'b0;
    end else begin
      power_down  <= (next_state == ST_OFF) || (next_state == ST_RECH) ||
                     (next_state == ST_LATCH);
      latch_clamp <= (next_state == ST_LATCH);
    end
  end

  // ***********************************************************
  // soft-start and peak limit
  // ***********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ss_pre <= '0;
      ramp   <= '0;
    end else if (!st_run) begin
      ss_pre <= '0;
      ramp   <= '0;
    end else if (ss_pre == SSW'(SS_STEP - 1)) begin
      ss_pre <= '0;
      if (ramp != PW'(PEAK_MAX)) ramp <= ramp + 1'b1;
    end else begin
      ss_pre <= ss_pre + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      peak_limit <= '0;
    end else if (low_power) begin
      peak_limit <= PEAK_LOW;
    end else begin
      peak_limit <= (ctrl_level < ramp) ? ctrl_level : ramp;
    end
  end

  // ***********************************************************
  // stroke timing
  // ***********************************************************
  assign sw.enable    = st_run && !fault_any;
  assign sw.low_power = low_power;
  assign sw.cs_trip   = current_sense_input;
  assign gate         = sw.gate;

  sps_stroke u_stroke (
    .mclk (mclk),
    .rst  (rst),
    .sw   (sw)
  );

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_opp_restart;
    st_run && opp_fire && !latch_fault;
  endsequence
  sequence s_last_recharge;
    state == ST_RECH && vcc_start && restart_left == 2'h1;
  endsequence

  a_start_gated: assert property ($rose(st_run) |-> $past(brownin_ok && protect_det))
    else $error("switching began without brown-in and protect level");
  a_soft_ramp: assert property (st_run && $past(st_run) |->
    (ramp == $past(ramp)) || (ramp == $past(ramp) + 1'b1))
    else $error("soft-start ramp jumped");
  a_fault_stops: assert property (st_run && fault_any |=> !gate)
    else $error("gate still high after a protection");
  a_die_latches: assert property (st_run && die_hot |=> state == ST_LATCH ##1 power_down)
    else $error("die overtemperature did not latch");
  a_opp_triple: assert property (s_opp_restart |=>
    restart_left == RESTART_TRIPLE && restart_cause == CS_OPP && state == ST_DISCH)
    else $error("overpower did not select triple restart");
  a_disch_waits: assert property (state == ST_DISCH && !undervoltage_lockout |=>
    state == ST_DISCH)
    else $error("restart left discharge before lockout level");
  a_resume_once: assert property (s_last_recharge |=> state == ST_WAIT)
    else $error("final recharge did not return to start wait");
  a_latch_holds: assert property (state == ST_LATCH |=> state == ST_LATCH && latch_clamp)
    else $error("latched state released without reset");
  a_brownout_single: assert property (st_run && bo_fire && !latch_fault && !opp_fire |=>
    restart_left == RESTART_SINGLE && !gate)
    else $error("brownout did not give a single restart");
  a_maxduty_trip: assert property (st_run && md_fire && !latch_fault |=> state == ST_DISCH)
    else $error("eight max-duty strokes did not restart");
  a_mains_store: assert property (phase_end && measure_mains |=>
    stored_current == $past(mains_current) && !measure_mains)
    else $error("mains current not stored at end of mains phase");
  a_low_peak: assert property (low_power |=> peak_limit == PEAK_LOW)
    else $error("low power peak not fixed");
endmodule // sps_top

// *** sim/sps_stage_model.sv ***
// behavioural flyback stage: supply capacitor, aux winding and sense current
`timescale 1ns/10ps
module sps_stage_model #(
  parameter int START_LVL = 80,
  parameter int UNDERVOLTAGE_LOCKOUT_LVL  = 40,
  parameter int RUN_LVL   = 90,
  parameter int CLAMP_LVL = 20,
  parameter int DIS_DIV   = 48
)(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       gate,
  input  wire logic       power_down,
  input  wire logic       latch_clamp,
  input  wire logic       aux_fail,
  input  wire logic       cs_stuck,
  input  wire logic [7:0] cs_delay,
  output logic            vcc_start,
  output logic            undervoltage_lockout,
  output logic            current_sense_input
);
  int vcc;
  int tick;
  int idle;
  int on_cnt;
  // ***********************************************************
  // supply capacitor and sense
  // ***********************************************************
  always @(negedge mclk) begin
    if (rst) begin
      vcc = 0;
      tick = 0;
      idle = 1000;
      on_cnt = 0;
    end else begin
      tick++;
      idle = gate ? 0 : (idle < 1000 ? idle + 1 : idle);
      if (latch_clamp)
        vcc = CLAMP_LVL;
      // aux winding holds the supply only while strokes keep coming
      else if (idle < 800 && !aux_fail)
        vcc = RUN_LVL;
      else if (power_down && tick % 4 == 0 && vcc < START_LVL)
        vcc++;
      // slow enough that a restart takes thousands of cycles
      else if (!power_down && tick % DIS_DIV == 0 && vcc > 0)
        vcc--;
      on_cnt = gate ? on_cnt + 1 : 0;
    end
    vcc_start = vcc >= START_LVL;
    undervoltage_lockout = vcc <= UNDERVOLTAGE_LOCKOUT_LVL;
    current_sense_input = gate && !cs_stuck && on_cnt >= cs_delay;
  end
endmodule // sps_stage_model

// *** sim/test_smps_protection_sequencer.sv ***
// self-checking bench for the start-up and protection sequencer
`timescale 1ns/10ps
module test_smps_protection_sequencer;
  import sps_pkg::*;
  logic       mclk = 0, rst = 1, vcc_ovp = 0, protect_det = 0, overload = 0;
  logic       low_power = 0, die_hot = 0, aux_fail = 0, cs_stuck = 0;
  logic       vcc_start, undervoltage_lockout, current_sense_input;
  logic       gate, power_down, latch_clamp, measure_mains;
  logic [7:0] mains_current = 8'h00, ctrl_level = 8'hC8, cs_delay = 8'h40;
  logic [7:0] peak_limit, stored_current, mv;
  sps_cause_t restart_cause;
  int         num_errors = 0, checked = 0, seed = 41139, hi = 0, hi_max = 0, n;
  int         exp_q[$];
  always #20 mclk = ~mclk;
  sps_top #(.SS_CYCLES(2550), .BO_CYCLES(200), .OPP_CYCLES(300)) sps_top_inst (
    .mclk(mclk), .rst(rst), .vcc_start(vcc_start),
    .undervoltage_lockout(undervoltage_lockout), .vcc_ovp(vcc_ovp),
    .protect_det(protect_det), .mains_current(mains_current), .ctrl_level(ctrl_level),
    .overload(overload), .current_sense_input(current_sense_input),
    .low_power(low_power), .die_hot(die_hot), .gate(gate), .peak_limit(peak_limit),
    .power_down(power_down), .latch_clamp(latch_clamp), .measure_mains(measure_mains),
    .stored_current(stored_current), .restart_cause(restart_cause));
  sps_stage_model sps_stage_model_inst (
    .mclk(mclk), .rst(rst), .gate(gate), .power_down(power_down),
    .latch_clamp(latch_clamp), .aux_fail(aux_fail), .cs_stuck(cs_stuck),
    .cs_delay(cs_delay), .vcc_start(vcc_start),
    .undervoltage_lockout(undervoltage_lockout),
    .current_sense_input(current_sense_input));
  // longest gate-high run, for the duty limit
  always @(negedge mclk) begin
    hi = (gate === 1'b1) ? hi + 1 : 0;
    if (hi > hi_max) hi_max = hi;
  end
  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // kind 0: gate high, 1: given cause recorded, 2: temperature phase
  task automatic wait_for(input int kind, input int bound, input sps_cause_t c);
    int w;
    w = 0;
    while (!(kind == 0 ? gate === 1'b1 : kind == 1 ? restart_cause === c
             : measure_mains === 1'b0) && w < bound) begin
      @(negedge mclk);
      w++;
    end
    if (w >= bound) begin
      num_errors++;
      $display("FAIL wait kind %0d expected 1 seen 0", kind);
      complete_run();
    end
  endtask
  // reference: opp restarts three times, every other cause once
  task automatic restart(input sps_cause_t c);
    int   rises;
    int   w;
    logic pd;
    wait_for(1, 25000, c);
    exp_q.push_back(c);
    {overload, cs_stuck, vcc_ovp, aux_fail, protect_det, mains_current} = {5'h01, mv};
    chk("gate stop", 0, gate);
    chk("discharge awake", 0, power_down);
    rises = 0;
    w = 0;
    pd = power_down;
    while (gate !== 1'b1 && w < 40000) begin
      @(negedge mclk);
      w++;
      if (power_down === 1'b1 && pd === 1'b0) rises++;
      pd = power_down;
    end
    wait_for(0, 1, CS_NONE);
    chk("recharges", exp_q.pop_front() == CS_OPP ? 3 : 1, rises);
    $display("test restart cause %0d done", c);
  endtask
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    mv = 8'h41 + 8'($unsigned($random(seed)) % 191);
    cs_delay = 8'h20 + 8'($unsigned($random(seed)) % 128);
    cyc(12);
    rst = 0;
    chk("reset pd", 1, power_down);
    chk("reset phase", 1, measure_mains);
    chk("reset stored", 0, stored_current);
    chk("reset cause", CS_NONE, restart_cause);
    mains_current = 8'h1E;
    protect_det = 1;
    wait_for(2, 6000, CS_NONE);
    chk("stored low", 8'h1E, stored_current);
    n = 0;
    while (measure_mains === 1'b0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk("temp phase len", PHASE_CYC, n);
    mains_current = mv;
    protect_det = 0;
    cyc(5200);
    chk("stored high", mv, stored_current);
    chk("no start", 0, hi_max);
    protect_det = 1;
    wait_for(0, 12000, CS_NONE);
    cyc(100);
    chk("ramping", 1, peak_limit < ctrl_level);
    cyc(2600);
    chk("ramp end", ctrl_level, peak_limit);
    low_power = 1;
    cyc(3);
    chk("low peak", 8'h3F, peak_limit);
    low_power = 0;
    $display("test start-up done");
    hi_max = 0;
    cs_stuck = 1;
    restart(CS_MAXD);
    chk("duty limit", MAX_DUTY_CYC, hi_max);
    overload = 1;
    restart(CS_OPP);
    mains_current = 8'h1E;
    restart(CS_BO);
    // two runs of two or three high cycles: only a cleared count keeps below four
    vcc_ovp = 1;
    cyc(1000);
    vcc_ovp = 0;
    cyc(800);
    vcc_ovp = 1;
    cyc(1000);
    chk("ovp short", CS_BO, restart_cause);
    vcc_ovp = 1;
    restart(CS_OVP);
    aux_fail = 1;
    restart(CS_UNDERVOLTAGE_LOCKOUT);
    protect_det = 0;
    cyc(12000);
    protect_det = 1;
    cyc(5200);
    protect_det = 0;
    cyc(12000);
    chk("otp cleared", CS_UNDERVOLTAGE_LOCKOUT, restart_cause);
    restart(CS_OTP);
    die_hot = 1;
    cyc(3);
    die_hot = 0;
    chk("latch clamp", 1, latch_clamp);
    chk("latch pd", 1, power_down);
    hi_max = 0;
    cyc(2000);
    chk("latch held", 1, latch_clamp);
    chk("latch off", 0, hi_max);
    rst = 1;
    cyc(2);
    rst = 0;
    chk("latch release", 0, latch_clamp);
    $display("test latch done");
    complete_run();
  end
endmodule // test_smps_protection_sequencer
